/* design/ias_pkg.sv */
// Constants and types shared by the interrupt acceptance sequencer
package ias_pkg;
   localparam int NUM_MSK = 8;
   localparam int ADDR_W = 16;

   // Register indices on the plain register port
   localparam logic [1:0] REG_CTRL = 2'h0;
   localparam logic [1:0] REG_ENABLE = 2'h1;
   localparam logic [1:0] REG_LATCH = 2'h2;
   localparam logic [1:0] REG_STATUS = 2'h3;

   // Field positions
   localparam int CTRL_IMF_BIT = 0;
   localparam int CTRL_TRAP_INT_BIT = 1;
   localparam int STATUS_IMF_BIT = 0;

   // Values after reset
   localparam logic CTRL_IMF_RST = 1'b0;
   localparam logic CTRL_TRAP_INT_RST = 1'b0;
   localparam logic [NUM_MSK-1:0] ENABLE_RST = 8'h00;
   localparam logic [NUM_MSK-1:0] LATCH_RST = 8'h00;
   localparam logic [ADDR_W-1:0] SP_RST = 16'h0000;

   // Sequence lengths in machine cycles (one clock per machine cycle)
   localparam int ACCEPT_CYCLES = 8;
   localparam logic [2:0] ACC_LAST = 3'(ACCEPT_CYCLES - 1);
   localparam logic [2:0] RET_LAST = 3'h4;

   // Source slots, lowest number is highest priority
   localparam logic [3:0] SLOT_SWI = 4'h0;
   localparam logic [3:0] SLOT_UNDEF = 4'h1;
   localparam logic [3:0] SLOT_TRAP = 4'h2;
   localparam logic [3:0] SLOT_MSK0 = 4'h3;
   localparam logic [ADDR_W-1:0] VEC_TOP = 16'hFFFE;

   // Address map used to classify instruction fetches
   localparam logic [ADDR_W-1:0] SFR_LO = 16'h0000;
   localparam logic [ADDR_W-1:0] SFR_HI = 16'h003F;
   localparam logic [ADDR_W-1:0] RAM_LO = 16'h0040;
   localparam logic [ADDR_W-1:0] RAM_HI = 16'h083F;
   localparam logic [ADDR_W-1:0] DBR_LO = 16'h0F80;
   localparam logic [ADDR_W-1:0] DBR_HI = 16'h0FFF;
   localparam logic [ADDR_W-1:0] ROM_LO = 16'h4000;
   localparam logic [7:0] SOFT_TRAP_OPCODE = 8'hFF;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ACCEPT = 2'b01,
      ST_RETURN = 2'b10
   } ias_state_t;

   typedef struct packed {
      logic we;
      logic re;
      logic [ADDR_W-1:0] addr;
      logic [7:0] wdata;
   } ias_mem_req_t;

   typedef struct packed {
      logic load;
      logic [ADDR_W-1:0] pc;
   } ias_pc_load_t;
endpackage

/* design/ias_sequencer.sv */
// Interrupt acceptance and return sequencer for an 8-bit core
// What this block does
// - A set request latch holds until accepted, reset, or cleared by software.
// - Acceptance after the current instruction takes exactly eight machine cycles.
// - Servicing ends on the maskable or non-maskable return instruction.
// - Acceptance clears the master interrupt enable.
// - Acceptance clears only the accepted source's request latch.
// - Push status word, PC high, PC low; stack pointer drops by three.
// - Load PC from the source's vector slot, then run that code.
// - Enabled request starts acceptance within 38 oscillator periods worst case.
// - Master enable at zero blocks every maskable request.
// - Only PC and status word are saved automatically.
// - Saved PC low lands at SP+1, high byte at SP+2.
// - Requests sampled in each instruction's last cycle, also after returns.
// - Soft trap opcode starts software interrupt at once, highest priority.
// - Fetch from non-existent address in single-chip mode yields FFH.
// - Fetch from RAM, data buffer or special register area is trapped.
// - Undefined opcode interrupts at once, even during non-maskable service.
// - Fetch trap interrupts at once, even during non-maskable service.
// - Watchdog control setting chooses reset output or trap interrupt.
// - Either return reloads master enable from the stacked status word.
// - Maskable accepted only with master enable, own enable and latch set.
// - Non-maskable sources ignore master and individual enables.
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module ias_sequencer (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic [1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   output logic [7:0] reg_rdata_o,
   input wire logic [ias_pkg::NUM_MSK-1:0] irq_req_i,
   input wire logic instr_last_i,
   input wire logic swi_exec_i,
   input wire logic undef_exec_i,
   input wire logic ret_maskable_i,
   input wire logic ret_nonmask_i,
   input wire logic fetch_valid_i,
   input wire logic [ias_pkg::ADDR_W-1:0] fetch_addr_i,
   input wire logic single_chip_i,
   input wire logic [ias_pkg::ADDR_W-1:0] pc_i,
   input wire logic [ias_pkg::ADDR_W-1:0] sp_i,
   input wire logic [7:0] status_word_i,
   input wire logic [7:0] mem_rdata_i,
   output ias_pkg::ias_mem_req_t mem_req_o,
   output ias_pkg::ias_pc_load_t pc_load_o,
   output logic [ias_pkg::ADDR_W-1:0] sp_o,
   output logic sp_load_o,
   output logic [7:0] status_word_o,
   output logic status_load_o,
   output logic busy_o,
   output logic abort_o,
   output logic fetch_force_o,
   output logic [7:0] fetch_data_o,
   output logic trap_reset_o,
   output logic master_irq_enable_o
);
   import ias_pkg::*;

   ias_state_t state_r;
   logic [2:0] step_r;
   logic master_irq_enable_r;
   logic trap_int_mode_r;
   logic [NUM_MSK-1:0] source_enable_flag_r;
   logic [NUM_MSK-1:0] request_latch_r;
   logic swi_pend_r, undef_pend_r, trap_pend_r;
   logic sample_pend_r;
   logic nmi_active_r, msk_active_r;
   logic [3:0] slot_r;
   logic [ADDR_W-1:0] ret_pc_r;
   logic [7:0] psw_r;
   logic [ADDR_W-1:0] sp_r;
   logic [7:0] vec_lo_r, pop_lo_r, pop_hi_r;
   logic ret_nm_r;

   logic idle, sample, start_nm, start_msk, start_any, start_ret;
   logic trap_fetch, nonexist_fetch;
   logic [NUM_MSK-1:0] msk_elig, sel_oh;
   logic [3:0] sel_slot;

   function automatic logic in_range(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] lo,
                                     input logic [ADDR_W-1:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   function automatic logic [ADDR_W-1:0] vec_addr(input logic [3:0] slot);
      vec_addr = VEC_TOP - {11'h000, slot, 1'b0};
   endfunction

   // Fetch classification
   always_comb begin
      trap_fetch = fetch_valid_i && (in_range(fetch_addr_i, SFR_LO, SFR_HI) ||
                   in_range(fetch_addr_i, RAM_LO, RAM_HI) ||
                   in_range(fetch_addr_i, DBR_LO, DBR_HI));
      nonexist_fetch = fetch_valid_i && single_chip_i && !trap_fetch &&
                       (fetch_addr_i < ROM_LO);
   end

   // Arbitration
   always_comb begin
      idle = (state_r == ST_IDLE);
      sample = instr_last_i || sample_pend_r;
      msk_elig = request_latch_r & source_enable_flag_r &
                 {NUM_MSK{master_irq_enable_r}};
      start_nm = idle && (swi_pend_r || undef_pend_r || trap_pend_r);
      start_msk = idle && sample && (|msk_elig) && !start_nm;
      start_any = start_nm || start_msk;
      start_ret = idle && !start_any && (ret_maskable_i || ret_nonmask_i);
      sel_oh = msk_elig & (~msk_elig + {{(NUM_MSK-1){1'b0}}, 1'b1});
      sel_slot = SLOT_SWI;
      if (swi_pend_r) begin
         sel_slot = SLOT_SWI;
      end else if (undef_pend_r) begin
         sel_slot = SLOT_UNDEF;
      end else if (trap_pend_r) begin
         sel_slot = SLOT_TRAP;
      end else begin
         for (int i = 0; i < NUM_MSK; i++) begin
            if (sel_oh[i]) begin
               sel_slot = SLOT_MSK0 + 4'(i);
            end
         end
      end
   end

   // Sequencer state
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         state_r <= ST_IDLE;
         step_r <= 3'h0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               step_r <= 3'h0;
               if (start_any) begin
                  state_r <= ST_ACCEPT;
               end else if (start_ret) begin
                  state_r <= ST_RETURN;
               end
            end
            ST_ACCEPT: begin
               if (step_r == ACC_LAST) begin
                  state_r <= ST_IDLE;
                  step_r <= 3'h0;
               end else begin
                  step_r <= step_r + 3'h1;
               end
            end
            ST_RETURN: begin
               if (step_r == RET_LAST) begin
                  state_r <= ST_IDLE;
                  step_r <= 3'h0;
               end else begin
                  step_r <= step_r + 3'h1;
               end
            end
            default: begin
               state_r <= ST_IDLE;
               step_r <= 3'h0;
            end
         endcase
      end
   end

   // Context captured when a sequence starts
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         slot_r <= SLOT_SWI;
         ret_pc_r <= '0;
         psw_r <= 8'h00;
         ret_nm_r <= 1'b0;
      end else if (start_any) begin
         slot_r <= sel_slot;
         ret_pc_r <= pc_i;
         psw_r <= status_word_i;
         psw_r[STATUS_IMF_BIT] <= master_irq_enable_r;
      end else if (start_ret) begin
         ret_nm_r <= ret_nonmask_i;
      end
   end

   // Stack and vector traffic; general registers are left to software
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         mem_req_o <= '0;
         pc_load_o <= '0;
         sp_r <= SP_RST;
         sp_o <= SP_RST;
         sp_load_o <= 1'b0;
         status_load_o <= 1'b0;
         status_word_o <= 8'h00;
         vec_lo_r <= 8'h00;
         pop_lo_r <= 8'h00;
         pop_hi_r <= 8'h00;
      end else begin
         mem_req_o <= '0;
         pc_load_o <= '0;
         sp_load_o <= 1'b0;
         status_load_o <= 1'b0;
         if (start_any || start_ret) begin
            sp_r <= sp_i;
         end
         if (state_r == ST_ACCEPT) begin
            case (step_r)
               3'h0: begin
                  mem_req_o <= '{we: 1'b1, re: 1'b0, addr: sp_r, wdata: psw_r};
                  sp_r <= sp_r - 16'h0001;
               end
               3'h1: begin
                  mem_req_o <= '{we: 1'b1, re: 1'b0, addr: sp_r, wdata: ret_pc_r[15:8]};
                  sp_r <= sp_r - 16'h0001;
               end
               3'h2: begin
                  mem_req_o <= '{we: 1'b1, re: 1'b0, addr: sp_r, wdata: ret_pc_r[7:0]};
                  sp_r <= sp_r - 16'h0001;
               end
               3'h3: begin
                  mem_req_o <= '{we: 1'b0, re: 1'b1, addr: vec_addr(slot_r), wdata: 8'h00};
               end
               3'h4: begin
                  mem_req_o <= '{we: 1'b0, re: 1'b1, addr: vec_addr(slot_r) + 16'h0001,
                                 wdata: 8'h00};
               end
               3'h5: begin
                  vec_lo_r <= mem_rdata_i;
               end
               3'h6: begin
                  pc_load_o <= '{load: 1'b1, pc: {mem_rdata_i, vec_lo_r}};
                  sp_load_o <= 1'b1;
                  sp_o <= sp_r;
               end
               default: begin
                  sp_load_o <= 1'b0;
               end
            endcase
         end else if (state_r == ST_RETURN) begin
            if (step_r <= 3'h2) begin
               mem_req_o <= '{we: 1'b0, re: 1'b1, addr: sp_r + 16'h0001, wdata: 8'h00};
               sp_r <= sp_r + 16'h0001;
            end
            if (step_r == 3'h2) begin
               pop_lo_r <= mem_rdata_i;
            end
            if (step_r == 3'h3) begin
               pop_hi_r <= mem_rdata_i;
            end
            if (step_r == RET_LAST) begin
               pc_load_o <= '{load: 1'b1, pc: {pop_hi_r, pop_lo_r}};
               status_word_o <= mem_rdata_i;
               status_load_o <= 1'b1;
               sp_load_o <= 1'b1;
               sp_o <= sp_r;
            end
         end
      end
   end

   // Master enable: accept clears, return restores, otherwise software
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         master_irq_enable_r <= CTRL_IMF_RST;
      end else if (start_any) begin
         master_irq_enable_r <= 1'b0;
      end else if (state_r == ST_RETURN && step_r == RET_LAST) begin
         master_irq_enable_r <= mem_rdata_i[STATUS_IMF_BIT];
      end else if (reg_we_i && reg_addr_i == REG_CTRL) begin
         master_irq_enable_r <= reg_wdata_i[CTRL_IMF_BIT];
      end
   end

   // Control and enable registers
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         trap_int_mode_r <= CTRL_TRAP_INT_RST;
         source_enable_flag_r <= ENABLE_RST;
      end else if (reg_we_i) begin
         if (reg_addr_i == REG_CTRL) begin
            trap_int_mode_r <= reg_wdata_i[CTRL_TRAP_INT_BIT];
         end
         if (reg_addr_i == REG_ENABLE) begin
            source_enable_flag_r <= reg_wdata_i;
         end
      end
   end

   // Request latches; a new request wins over any clear
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         request_latch_r <= LATCH_RST;
      end else begin
         request_latch_r <= (request_latch_r
            & ~((reg_we_i && reg_addr_i == REG_LATCH) ? ~reg_wdata_i : 8'h00)
            & ~(start_msk ? sel_oh : 8'h00))
            | irq_req_i;
      end
   end

   // Non-maskable pending flags; a new event wins over the acceptance clear
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         swi_pend_r <= 1'b0;
         undef_pend_r <= 1'b0;
         trap_pend_r <= 1'b0;
      end else begin
         swi_pend_r <= (swi_pend_r && !(start_nm && sel_slot == SLOT_SWI)) ||
                       swi_exec_i;
         undef_pend_r <= (undef_pend_r && !(start_nm && sel_slot == SLOT_UNDEF)) ||
                         undef_exec_i;
         trap_pend_r <= (trap_pend_r && !(start_nm && sel_slot == SLOT_TRAP)) ||
                        (trap_fetch && trap_int_mode_r);
      end
   end

   // Instruction end seen while busy is kept for the next idle cycle
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         sample_pend_r <= 1'b0;
      end else if (idle && !start_ret) begin
         sample_pend_r <= 1'b0;
      end else if (instr_last_i || start_ret) begin
         sample_pend_r <= 1'b1;
      end
   end

   // Service tracking
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         nmi_active_r <= 1'b0;
         msk_active_r <= 1'b0;
      end else if (start_nm) begin
         nmi_active_r <= 1'b1;
      end else if (start_msk) begin
         msk_active_r <= 1'b1;
      end else if (state_r == ST_RETURN && step_r == RET_LAST) begin
         if (ret_nm_r) begin
            nmi_active_r <= 1'b0;
         end else begin
            msk_active_r <= 1'b0;
         end
      end
   end

   // Register read port, data one cycle after the strobe
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_re_i) begin
         case (reg_addr_i)
            REG_CTRL: reg_rdata_o <= {6'h00, trap_int_mode_r, master_irq_enable_r};
            REG_ENABLE: reg_rdata_o <= source_enable_flag_r;
            REG_LATCH: reg_rdata_o <= request_latch_r;
            REG_STATUS: reg_rdata_o <= {slot_r, nmi_active_r, msk_active_r, state_r};
            default: reg_rdata_o <= 8'h00;
         endcase
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end

   // Fetch responses and status outputs
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         fetch_force_o <= 1'b0;
         fetch_data_o <= 8'h00;
         trap_reset_o <= 1'b0;
         abort_o <= 1'b0;
         busy_o <= 1'b0;
         master_irq_enable_o <= CTRL_IMF_RST;
      end else begin
         fetch_force_o <= nonexist_fetch;
         fetch_data_o <= nonexist_fetch ? SOFT_TRAP_OPCODE : 8'h00;
         trap_reset_o <= trap_fetch && !trap_int_mode_r;
         abort_o <= start_nm && (sel_slot == SLOT_UNDEF || sel_slot == SLOT_TRAP);
         busy_o <= start_any || start_ret ||
                   (state_r == ST_ACCEPT && step_r != ACC_LAST) ||
                   (state_r == ST_RETURN && step_r != RET_LAST);
         master_irq_enable_o <= start_any ? 1'b0 : master_irq_enable_r;
      end
   end

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);

   sequence s_accept_body;
      (state_r == ST_ACCEPT) [*8] ##1 (state_r != ST_ACCEPT);
   endsequence
   sequence s_push;
      (mem_req_o.we && mem_req_o.wdata == psw_r) ##1
      (mem_req_o.we && mem_req_o.wdata == ret_pc_r[15:8]) ##1
      (mem_req_o.we && mem_req_o.wdata == ret_pc_r[7:0]);
   endsequence

   property p_accept_len;
      start_any |=> s_accept_body;
   endproperty
   a_accept_len: assert property (p_accept_len) else $error("accept length wrong");

   property p_imf_clear;
      start_any |=> !master_irq_enable_r [*4];
   endproperty
   a_imf_clear: assert property (p_imf_clear) else $error("master enable not cleared");

   property p_latch_clear;
      (start_msk && ((irq_req_i & sel_oh) == 8'h00)) |=>
         ((request_latch_r & $past(sel_oh)) == 8'h00);
   endproperty
   a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared");

   property p_push_order;
      (state_r == ST_ACCEPT && step_r == 3'h0) |=> s_push;
   endproperty
   a_push_order: assert property (p_push_order) else $error("push order wrong");

   property p_sp_dec;
      start_any |-> ##4 (sp_r == $past(sp_i, 4) - 16'h0003);
   endproperty
   a_sp_dec: assert property (p_sp_dec) else $error("stack pointer not down by 3");

   property p_no_msk_off;
      !master_irq_enable_r |-> !start_msk;
   endproperty
   a_no_msk_off: assert property (p_no_msk_off) else $error("maskable taken while off");

   property p_latch_hold;
      (|($past(request_latch_r) & ~request_latch_r)) |->
         ($past(reg_we_i && reg_addr_i == REG_LATCH) || $past(start_msk));
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latch dropped");

   property p_swi_first;
      (idle && swi_pend_r) |-> (start_any && sel_slot == SLOT_SWI) ##1 busy_o;
   endproperty
   a_swi_first: assert property (p_swi_first) else $error("soft trap not first");

   property p_ret_imf;
      (state_r == ST_RETURN && step_r == RET_LAST) |=>
         (master_irq_enable_r == $past(mem_rdata_i[STATUS_IMF_BIT])) && status_load_o;
   endproperty
   a_ret_imf: assert property (p_ret_imf) else $error("enable not restored");
endmodule // ias_sequencer

/* dv/ias_stack_model.sv */
// Stack memory and stack pointer of the core beside the sequencer
`timescale 1ns/1ps
module ias_stack_model (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire ias_pkg::ias_mem_req_t mem_req_i,
   input wire logic [ias_pkg::ADDR_W-1:0] new_sp_i,
   input wire logic sp_load_i,
   output logic [7:0] mem_rdata_o,
   output logic [ias_pkg::ADDR_W-1:0] sp_o
);
   import ias_pkg::*;
   logic [7:0] mem [0:65535];
   logic [ADDR_W-1:0] sp_r;
   // Vector slot s holds entry {80h+s, s}; the rest is a fill pattern
   initial begin
      mem_rdata_o = 8'h00;
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 8'h5A;
      end
      for (int s = 0; s < 11; s++) begin
         mem[VEC_TOP - 16'(2 * s)] = 8'(s);
         mem[VEC_TOP - 16'(2 * s) + 16'h0001] = 8'h80 + 8'(s);
      end
   end
   always @(posedge ref_clk_i) begin
      if (mem_req_i.we) begin
         mem[mem_req_i.addr] <= mem_req_i.wdata;
      end
      // Idle read bus toggles so a late sample never sees stale data
      mem_rdata_o <= mem_req_i.re ? mem[mem_req_i.addr] : ~mem_rdata_o;
      sp_r <= reset_i ? 16'h0200 : (sp_load_i ? new_sp_i : sp_r);
   end
   // New SP shows at once so a back-to-back sequence uses it
   assign sp_o = sp_load_i ? new_sp_i : sp_r;
   // Handler rewrites the stacked return address before returning
   task automatic patch_return(input logic [15:0] sp, input logic [15:0] a);
      mem[sp + 16'h0001] = a[7:0];
      mem[sp + 16'h0002] = a[15:8];
   endtask
endmodule // ias_stack_model

/* dv/tb.sv */
// Self-checking bench for the interrupt acceptance sequencer
`timescale 1ns/1ps
module tb;
   import ias_pkg::*;
   logic ref_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [1:0] reg_addr_i = 2'h0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_we_i = 1'b0;
   logic reg_re_i = 1'b0;
   logic [NUM_MSK-1:0] irq_req_i = 8'h00;
   logic instr_last_i = 1'b0;
   logic swi_exec_i = 1'b0;
   logic undef_exec_i = 1'b0;
   logic ret_maskable_i = 1'b0;
   logic ret_nonmask_i = 1'b0;
   logic fetch_valid_i = 1'b0;
   logic [ADDR_W-1:0] fetch_addr_i = 16'h4000;
   logic [ADDR_W-1:0] pc_i = 16'h4567;
   logic [7:0] status_word_i = 8'hA0;
   logic single_chip_i = 1'b1;
   logic [ADDR_W-1:0] sp_i, sp_o, pc_got, sp_got;
   logic [7:0] reg_rdata_o, mem_rdata_i, status_word_o, fetch_data_o, rd_got, st_got, fd_got;
   ias_mem_req_t mem_req_o;
   ias_pc_load_t pc_load_o;
   logic sp_load_o, status_load_o, busy_o, abort_o, fetch_force_o, trap_reset_o;
   logic master_irq_enable_o, ab_got;
   logic [1:0] f_got;
   int fail_count = 0;
   int comparisons = 0;
   int n;

   ias_sequencer u_ias_sequencer (.ref_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_we_i,
      .reg_re_i, .reg_rdata_o, .irq_req_i, .instr_last_i, .swi_exec_i, .undef_exec_i,
      .ret_maskable_i, .ret_nonmask_i, .fetch_valid_i, .fetch_addr_i, .single_chip_i,
      .pc_i, .sp_i, .status_word_i, .mem_rdata_i, .mem_req_o, .pc_load_o, .sp_o, .sp_load_o,
      .status_word_o, .status_load_o, .busy_o, .abort_o, .fetch_force_o, .fetch_data_o,
      .trap_reset_o, .master_irq_enable_o);
   ias_stack_model u_ias_stack_model (.ref_clk_i, .reset_i, .mem_req_i(mem_req_o),
      .new_sp_i(sp_o), .sp_load_i(sp_load_o), .mem_rdata_o(mem_rdata_i), .sp_o(sp_i));

   always #4 ref_clk_i = ~ref_clk_i;

   function automatic logic [15:0] vec(input int s);
      return {8'h80 + 8'(s), 8'(s)};
   endfunction
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      reg_we_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge ref_clk_i);
      reg_we_i <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a);
      @(posedge ref_clk_i);
      reg_re_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge ref_clk_i);
      reg_re_i <= 1'b0;
      #1;
      rd_got = reg_rdata_o;
   endtask
   // Drops every one-cycle input, then watches up to 20 cycles for a PC load
   task automatic seq();
      n = 0;
      ab_got = 1'b0;
      pc_got = 16'h0000;
      for (int i = 0; i < 20 && n == 0; i++) begin
         @(posedge ref_clk_i);
         instr_last_i <= 1'b0;
         swi_exec_i <= 1'b0;
         undef_exec_i <= 1'b0;
         ret_maskable_i <= 1'b0;
         ret_nonmask_i <= 1'b0;
         fetch_valid_i <= 1'b0;
         irq_req_i <= 8'h00;
         #1;
         ab_got |= abort_o;
         if (i == 0) begin
            f_got = {fetch_force_o, trap_reset_o};
            fd_got = fetch_data_o;
         end
         if (pc_load_o.load === 1'b1) begin
            n = i + 1;
            pc_got = pc_load_o.pc;
            sp_got = sp_o;
            st_got = status_word_o;
         end
      end
   endtask
   task automatic fetch(input logic [15:0] a, input logic sc);
      @(posedge ref_clk_i);
      fetch_valid_i <= 1'b1;
      fetch_addr_i <= a;
      single_chip_i <= sc;
      seq();
   endtask

   task automatic t_reset();
      rd(REG_CTRL);
      check("ctrl", 16'(rd_got), 16'h0000);
      rd(REG_ENABLE);
      check("enable", 16'(rd_got), 16'h0000);
      rd(REG_LATCH);
      check("latch", 16'(rd_got), 16'h0000);
      $display("test reset done");
   endtask
   task automatic t_mask();
      wr(REG_ENABLE, 8'h24);
      @(posedge ref_clk_i);
      irq_req_i <= 8'h24;
      instr_last_i <= 1'b1;
      seq();
      check("masked load", 16'(n), 16'h0000);
      rd(REG_LATCH);
      check("latch held", 16'(rd_got), 16'h0024);
      wr(REG_CTRL, 8'h01);
      @(posedge ref_clk_i);
      instr_last_i <= 1'b1;
      seq();
      check("accept cycles", 16'(n), 16'h0008);
      check("busy", 16'(busy_o), 16'h0001);
      check("vector", pc_got, vec(5));
      check("sp", sp_got, 16'h01FD);
      check("push status", 16'(u_ias_stack_model.mem[16'h0200]), 16'h00A1);
      check("push low", 16'(u_ias_stack_model.mem[sp_got + 16'h0001]), 16'h0067);
      check("push high", 16'(u_ias_stack_model.mem[sp_got + 16'h0002]), 16'h0045);
      check("no extra push", 16'(u_ias_stack_model.mem[16'h01FD]), 16'h005A);
      check("imf", 16'(master_irq_enable_o), 16'h0000);
      rd(REG_LATCH);
      check("latch after", 16'(rd_got), 16'h0020);
      $display("test maskable done");
   endtask
   task automatic t_return();
      @(posedge ref_clk_i);
      ret_maskable_i <= 1'b1;
      seq();
      check("ret pc", pc_got, 16'h4567);
      check("ret sp", sp_got, 16'h0200);
      check("ret status", 16'(st_got), 16'h00A1);
      seq();
      check("pending taken", pc_got, vec(8));
      check("imf restored", 16'(u_ias_stack_model.mem[16'h0200]), 16'h00A1);
      $display("test return done");
   endtask
   task automatic t_soft();
      wr(REG_CTRL, 8'h01);
      @(posedge ref_clk_i);
      irq_req_i <= 8'h04;
      swi_exec_i <= 1'b1;
      @(posedge ref_clk_i);
      irq_req_i <= 8'h00;
      swi_exec_i <= 1'b0;
      instr_last_i <= 1'b1;
      seq();
      check("soft first", pc_got, vec(0));
      rd(REG_LATCH);
      check("latch kept", 16'(rd_got), 16'h0004);
      @(posedge ref_clk_i);
      undef_exec_i <= 1'b1;
      seq();
      check("undef vector", pc_got, vec(1));
      check("undef abort", 16'(ab_got), 16'h0001);
      wr(REG_LATCH, 8'hFB);
      rd(REG_LATCH);
      check("latch cleared", 16'(rd_got), 16'h0000);
      $display("test soft done");
   endtask
   task automatic t_fetch();
      fetch(16'h2000, 1'b0);
      check("no force", 16'(f_got), 16'h0000);
      fetch(16'h2000, 1'b1);
      check("force", 16'(f_got), 16'h0002);
      check("force data", 16'(fd_got), 16'h00FF);
      fetch(16'h0040, 1'b1);
      check("trap reset", 16'(f_got), 16'h0001);
      wr(REG_CTRL, 8'h02);
      fetch(16'h0F80, 1'b1);
      check("trap vector", pc_got, vec(2));
      check("trap abort", 16'(ab_got), 16'h0001);
      u_ias_stack_model.patch_return(sp_got, 16'h4100);
      @(posedge ref_clk_i);
      ret_nonmask_i <= 1'b1;
      seq();
      check("return_nonmaskable pc", pc_got, 16'h4100);
      $display("test fetch done");
   endtask

   initial begin
      repeat (3) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      t_reset();
      t_mask();
      t_return();
      t_soft();
      t_fetch();
      close_out();
   end
   initial begin
      #(3000 * 8);
      fail_count++;
      close_out();
   end
endmodule // tb
